/* File: hdl/adc_ctrl_pkg.sv */
// Behaviour
// - Serial result output changes only on falling serial clock edges.
// - Serial result output is high impedance while chip select is high.
// - Serial input is ignored while chip select is high.
// - Input bits are captured on rising serial clock edges.
// - Internal clock mode: strobe low at conversion start, high when done.
// - External clock mode: strobe high one serial period before MSB decision.
// - External clock mode: strobe high impedance while chip select is high.
// - Shutdown input low means hardware power-down; other levels operate.
// - Shutdown input at middle level runs internal clock at 1.5MHz.
// - Shutdown input high runs internal clock at 225kHz.
// - External mode paces approximation steps with the serial clock.
// - Sampler starts tracking on falling edge after fifth control bit of the first frame after reset.
// - Sampler holds on falling edge after eighth bit, conversion starts.
// - Single-ended: selected channel to positive node, common to negative.
// - Differential: inputs taken only from pairs 0/1, 2/3, 4/5, 6/7.
// - Each conversion yields a 12-bit word from positive minus negative.
// - After conversion the positive input tracks the signal again.
// - Leading zeros ignored; first one bit starts the control byte.
// - Control byte: start, selector[2:0], polarity, topology, power-down.
package adc_ctrl_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int RES_BITS = 12;
	localparam int CHANNELS = 8;

	// ------------------------------------------------------------
	// Control byte field positions
	// ------------------------------------------------------------
	localparam int CHANNEL_SELECT_MSB_POS = 6;
	localparam int SEL1_POS = 5;
	localparam int SEL0_POS = 4;
	localparam int POLARITY_POS = 3;
	localparam int TOPOLOGY_POS = 2;
	localparam int PD_HIGH_POS = 1;
	localparam int PD_LOW_POS = 0;
	localparam logic [1:0] PD_INTERNAL_CLOCK = 2'h2;

	// ------------------------------------------------------------
	// Serial bit counts, counted from the start bit as 1
	// ------------------------------------------------------------
	localparam logic [4:0] CNT_IDLE = 5'h00;
	localparam logic [4:0] CNT_FIRST = 5'h01;
	localparam logic [4:0] CNT_TRACK = 5'h05;
	localparam logic [4:0] CNT_HOLD = 5'h08;
	localparam logic [4:0] CNT_MSB = 5'h09;
	localparam logic [4:0] CNT_LSB = 5'h14;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	localparam logic [3:0] MSB_INDEX = 4'hB;

	// ------------------------------------------------------------
	// Shutdown pin levels and node codes
	// ------------------------------------------------------------
	localparam logic [1:0] THREE_LEVEL_SHUTDOWN_IN_LOW = 2'h0;
	localparam logic [1:0] THREE_LEVEL_SHUTDOWN_IN_MID = 2'h1;
	localparam logic [1:0] THREE_LEVEL_SHUTDOWN_IN_HIGH = 2'h2;
	localparam logic [3:0] NODE_COMMON = 4'h8;
	localparam logic [11:0] CODE_MID = 12'h800;
	localparam logic [11:0] CODE_POS_MAX = 12'h7FF;
	localparam logic [11:0] RESULT_RST = 12'h000;

	// ------------------------------------------------------------
	// Internal conversion clock
	// ------------------------------------------------------------
	localparam int REF_CLK_KHZ = 50000;
	localparam int INT_CLK_FAST_KHZ = 1500;
	localparam int INT_CLK_SLOW_KHZ = 225;
	localparam logic [7:0] FAST_DIV_CYC =
		8'(REF_CLK_KHZ / INT_CLK_FAST_KHZ);
	localparam logic [7:0] SLOW_DIV_CYC =
		8'(REF_CLK_KHZ / INT_CLK_SLOW_KHZ);

	typedef enum logic [0:0] {
		CONV_IDLE = 1'b0,
		CONV_RUN = 1'b1
	} conv_state_t;

	// One approximation step: keep trial bit if not above target
	function automatic logic [11:0] sarStep(input logic [11:0] target,
		input logic [11:0] acc, input logic [3:0] idx);
		logic [11:0] trial;
		trial = acc | (12'h001 << idx);
		sarStep = (trial <= target) ? trial : acc;
	endfunction

endpackage

/* File: hdl/sync_level.sv */
`timescale 1ns/1ps
module sync_level #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage <= '0;
			dout <= '0;
		end else begin
			stage <= din;
			dout <= stage;
		end
	end
endmodule

/* File: hdl/serial_adc_conversion_control.sv */
`timescale 1ns/1ps
module serial_adc_conversion_control (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic csn,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOutEn,
	output logic conversion_strobe_out,
	output logic conversionStrobeOutEn,
	input wire logic [1:0] three_level_shutdown_in,
	input wire logic [adc_ctrl_pkg::CHANNELS*adc_ctrl_pkg::RES_BITS-1:0]
		analog_input_channels,
	input wire logic [adc_ctrl_pkg::RES_BITS-1:0] common_reference_input,
	output logic powerDown,
	output logic samplerTracking,
	output logic samplerHold,
	output logic [3:0] positiveNodeSel,
	output logic [3:0] negativeNodeSel,
	output logic polarity_select_flag,
	output logic input_topology_flag,
	output logic powerdown_select_high,
	output logic powerdown_select_low,
	output logic [adc_ctrl_pkg::RES_BITS-1:0] resultWord
);
	import adc_ctrl_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic frameRst;
	logic sclkN;
	logic [4:0] bitCnt;
	logic [4:0] next_bitCnt;
	logic [7:0] ctrlShift;
	logic [7:0] next_ctrlShift;
	logic startSeen;
	logic restartOk;

	logic extStrobe;
	logic extBusy;
	logic intWait;
	logic [3:0] intShiftLeft;
	logic [11:0] extAcc;
	logic [11:0] next_extAcc;
	logic [11:0] outShift;
	logic doutReg;

	logic trackArm;
	logic startTgl;
	logic cfgInternal;
	logic cfgBipolar;
	logic cfgSingle;
	logic [1:0] cfgPd;
	logic [3:0] cfgPos;
	logic [3:0] cfgNeg;
	logic [11:0] targetHeld;
	logic [11:0] resultExt;
	logic doneSyncLink;

	logic startSyncRef;
	logic doneTgl;
	logic [1:0] shdnSync;
	logic [7:0] divCnt;
	logic [7:0] divTop;
	logic intTick;
	conv_state_t convState;
	logic [11:0] intAcc;
	logic [11:0] intTarget;
	logic [3:0] intIdx;
	logic [11:0] resultInt;
	logic pending;

	// ------------------------------------------------------------
	// Channel routing and sample target
	// ------------------------------------------------------------
	logic [2:0] sel;
	logic single;
	logic bipolar;
	logic [3:0] posIdx;
	logic [3:0] negIdx;
	logic [11:0] posVal;
	logic [11:0] negVal;
	logic [12:0] diff;
	logic tooBig;
	logic tooSmall;
	logic [11:0] clampVal;
	logic [11:0] targetNow;
	logic [2:0] seChan;
	logic [2:0] pairLow;

	assign sel = {ctrlShift[CHANNEL_SELECT_MSB_POS], ctrlShift[SEL1_POS],
		ctrlShift[SEL0_POS]};
	assign single = ctrlShift[TOPOLOGY_POS];
	assign bipolar = !ctrlShift[POLARITY_POS];
	// Selector bit 2 picks the odd channel of a pair
	assign seChan = {sel[1], sel[0], sel[2]};
	assign pairLow = {sel[1], sel[0], 1'b0};
	assign posIdx = single ? {1'b0, seChan} :
		{1'b0, pairLow[2:1], sel[2]};
	assign negIdx = single ? NODE_COMMON :
		{1'b0, pairLow[2:1], !sel[2]};

	function automatic logic [11:0] nodeValue(input logic [3:0] idx,
		input logic [CHANNELS*RES_BITS-1:0] chans,
		input logic [11:0] common);
		nodeValue = (idx == NODE_COMMON) ? common :
			chans[idx[2:0]*RES_BITS +: RES_BITS];
	endfunction

	assign posVal = nodeValue(posIdx, analog_input_channels,
		common_reference_input);
	assign negVal = nodeValue(negIdx, analog_input_channels,
		common_reference_input);
	assign diff = {1'b0, posVal} - {1'b0, negVal};
	assign tooBig = !diff[12] && diff[11];
	assign tooSmall = diff[12] && !diff[11];
	assign clampVal = tooBig ? CODE_POS_MAX :
		(tooSmall ? CODE_MID : diff[11:0]);
	// Bipolar runs on offset binary and is flipped back to two's complement
	assign targetNow = bipolar ? (clampVal ^ CODE_MID) :
		(diff[12] ? RESULT_RST : diff[11:0]);

	// ------------------------------------------------------------
	// Link side: control byte capture on rising edges
	// ------------------------------------------------------------
	assign frameRst = !rstn || csn || powerDown;
	assign sclkN = ~sclk;
	assign startSeen = (bitCnt != CNT_IDLE);
	assign restartOk = (bitCnt > CNT_LSB) && serialDataIn;

	always_comb begin
		next_bitCnt = bitCnt;
		next_ctrlShift = ctrlShift;
		if ((!startSeen && serialDataIn) || restartOk) begin
			next_bitCnt = CNT_FIRST;
			next_ctrlShift = 8'h01;
		end else if (startSeen) begin
			if (bitCnt != CNT_MAX) begin
				next_bitCnt = bitCnt + 5'h01;
			end
			if (bitCnt < CNT_HOLD) begin
				next_ctrlShift = {ctrlShift[6:0], serialDataIn};
			end
		end
	end

	always_ff @(posedge sclk or posedge frameRst) begin
		if (frameRst) begin
			bitCnt <= CNT_IDLE;
			ctrlShift <= 8'h00;
		end else begin
			bitCnt <= next_bitCnt;
			ctrlShift <= next_ctrlShift;
		end
	end

	// ------------------------------------------------------------
	// Link side: frame state on falling edges
	// ------------------------------------------------------------
	assign next_extAcc = sarStep(targetHeld, extAcc,
		4'(CNT_LSB - bitCnt));

	always_ff @(negedge sclk or posedge frameRst) begin
		if (frameRst) begin
			extStrobe <= 1'b0;
			extBusy <= 1'b0;
			intWait <= 1'b0;
			intShiftLeft <= 4'h0;
			extAcc <= RESULT_RST;
			outShift <= RESULT_RST;
			doutReg <= 1'b0;
		end else if (bitCnt == CNT_HOLD) begin
			extStrobe <= !cfgFromCtrl(ctrlShift);
			extBusy <= !cfgFromCtrl(ctrlShift);
			intWait <= cfgFromCtrl(ctrlShift);
			extAcc <= RESULT_RST;
			doutReg <= 1'b0;
		end else if (extBusy && bitCnt >= CNT_MSB) begin
			extStrobe <= 1'b0;
			extAcc <= next_extAcc;
			doutReg <= next_extAcc[4'(CNT_LSB - bitCnt)] ^
				(cfgBipolar && bitCnt == CNT_MSB);
			extBusy <= (bitCnt != CNT_LSB);
		end else if (intWait && doneSyncLink == startTgl) begin
			intWait <= 1'b0;
			outShift <= resultInt;
			intShiftLeft <= MSB_INDEX;
			doutReg <= resultInt[11];
		end else if (intShiftLeft != 4'h0) begin
			intShiftLeft <= intShiftLeft - 4'h1;
			outShift <= {outShift[10:0], 1'b0};
			doutReg <= outShift[10];
		end else begin
			extStrobe <= 1'b0;
			doutReg <= 1'b0;
		end
	end

	function automatic logic cfgFromCtrl(input logic [7:0] c);
		cfgFromCtrl = ({c[PD_HIGH_POS], c[PD_LOW_POS]} == PD_INTERNAL_CLOCK);
	endfunction

	// ------------------------------------------------------------
	// Link side: sampler and configuration, kept across frames
	// ------------------------------------------------------------
	always_ff @(negedge sclk or negedge rstn) begin
		if (!rstn) begin
			trackArm <= 1'b0;
			startTgl <= 1'b0;
			cfgInternal <= 1'b0;
			cfgBipolar <= 1'b0;
			cfgSingle <= 1'b0;
			cfgPd <= 2'h0;
			cfgPos <= 4'h0;
			cfgNeg <= 4'h0;
			targetHeld <= RESULT_RST;
			resultExt <= RESULT_RST;
		end else if (!frameRst && bitCnt == CNT_TRACK) begin
			trackArm <= 1'b1;
		end else if (!frameRst && bitCnt == CNT_HOLD) begin
			cfgInternal <= cfgFromCtrl(ctrlShift);
			cfgBipolar <= bipolar;
			cfgSingle <= single;
			cfgPd <= {ctrlShift[PD_HIGH_POS], ctrlShift[PD_LOW_POS]};
			cfgPos <= posIdx;
			cfgNeg <= negIdx;
			targetHeld <= targetNow;
			startTgl <= startTgl ^ cfgFromCtrl(ctrlShift);
		end else if (!frameRst && extBusy && bitCnt == CNT_LSB) begin
			resultExt <= next_extAcc ^ (cfgBipolar ? CODE_MID : RESULT_RST);
		end
	end

	sync_level #(.WIDTH(1)) u_doneLink (
		.clk(sclkN),
		.rstn(rstn),
		.din(doneTgl),
		.dout(doneSyncLink)
	);

	// ------------------------------------------------------------
	// Reference side: shutdown pin and internal conversion clock
	// ------------------------------------------------------------
	sync_level #(.WIDTH(2)) u_three_level_shutdown_in (
		.clk(ref_clk),
		.rstn(rstn),
		.din(three_level_shutdown_in),
		.dout(shdnSync)
	);

	sync_level #(.WIDTH(1)) u_startRef (
		.clk(ref_clk),
		.rstn(rstn),
		.din(startTgl),
		.dout(startSyncRef)
	);

	assign divTop = (shdnSync == THREE_LEVEL_SHUTDOWN_IN_HIGH) ? SLOW_DIV_CYC - 8'h01 :
		FAST_DIV_CYC - 8'h01;
	assign intTick = (divCnt >= divTop);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			powerDown <= 1'b0;
			divCnt <= 8'h00;
		end else begin
			powerDown <= (shdnSync == THREE_LEVEL_SHUTDOWN_IN_LOW);
			divCnt <= (powerDown || intTick) ? 8'h00 : divCnt + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Reference side: internal clock mode conversion
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			convState <= CONV_IDLE;
			doneTgl <= 1'b0;
			intAcc <= RESULT_RST;
			intTarget <= RESULT_RST;
			intIdx <= 4'h0;
			resultInt <= RESULT_RST;
		end else begin
			case (convState)
				CONV_IDLE: begin
					if (startSyncRef != doneTgl) begin
						intTarget <= targetHeld;
						intAcc <= RESULT_RST;
						intIdx <= MSB_INDEX;
						convState <= CONV_RUN;
					end
				end
				CONV_RUN: begin
					if (intTick && !powerDown) begin
						intAcc <= sarStep(intTarget, intAcc, intIdx);
						intIdx <= intIdx - 4'h1;
						if (intIdx == 4'h0) begin
							resultInt <= sarStep(intTarget, intAcc, intIdx) ^
								(cfgBipolar ? CODE_MID : RESULT_RST);
							doneTgl <= startSyncRef;
							convState <= CONV_IDLE;
						end
					end
				end
				default: begin
					convState <= CONV_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign pending = startTgl ^ doneTgl;
	assign serialDataOut = doutReg;
	assign serialDataOutEn = !csn && !powerDown;
	assign conversion_strobe_out = cfgInternal ? !pending : extStrobe;
	assign conversionStrobeOutEn = cfgInternal ? !powerDown :
		(!csn && !powerDown);
	assign samplerHold = extBusy || pending;
	assign samplerTracking = trackArm && !samplerHold;
	assign positiveNodeSel = cfgPos;
	assign negativeNodeSel = cfgNeg;
	assign polarity_select_flag = !cfgBipolar;
	assign input_topology_flag = cfgSingle;
	assign powerdown_select_high = cfgPd[1];
	assign powerdown_select_low = cfgPd[0];
	assign resultWord = cfgInternal ? resultInt : resultExt;
endmodule

/* File: dv/adc_ctrl_asserts.sv */
`timescale 1ns/1ps
module adc_ctrl_asserts
	import adc_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic csn,
	input wire logic serialDataIn,
	input wire logic serialDataOutEn,
	input wire logic conversion_strobe_out,
	input wire logic conversionStrobeOutEn,
	input wire logic [1:0] three_level_shutdown_in,
	input wire logic powerDown,
	input wire logic samplerTracking,
	input wire logic samplerHold,
	input wire logic [3:0] positiveNodeSel,
	input wire logic [3:0] negativeNodeSel,
	input wire logic input_topology_flag,
	input wire logic powerdown_select_high,
	input wire logic powerdown_select_low
);
	logic [4:0] cnt;
	wire ext = !(powerdown_select_high && !powerdown_select_low);

	// ------------------------------------------------------------
	// Bit count from the start bit
	// ------------------------------------------------------------
	always_ff @(posedge sclk or posedge csn or negedge rstn) begin
		if (!rstn)
			cnt <= CNT_IDLE;
		else if (csn)
			cnt <= CNT_IDLE;
		else if ((cnt != CNT_IDLE || serialDataIn) && cnt != CNT_MAX)
			cnt <= cnt + 5'h01;
	end

	a_track_at_five: assert property (@(posedge sclk)
		disable iff (!rstn || csn) cnt == CNT_TRACK |-> samplerTracking)
		else $error("sampler not tracking after fifth bit");
	a_hold_at_eight: assert property (@(posedge sclk)
		disable iff (!rstn || csn)
		cnt == CNT_HOLD && ext |-> samplerHold && !samplerTracking)
		else $error("sampler not holding after eighth bit");
	a_no_early_hold: assert property (@(posedge sclk)
		disable iff (!rstn || csn) cnt == 5'h07 |-> !samplerHold)
		else $error("sampler held too early");
	a_ext_strobe_pulse: assert property (@(posedge sclk)
		disable iff (!rstn || csn) cnt == CNT_HOLD && ext |->
		conversion_strobe_out ##1 !conversion_strobe_out)
		else $error("external strobe not one period");
	a_int_strobe_low: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		$rose(samplerHold) && !ext |->
		(!conversion_strobe_out && samplerHold) [*8])
		else $error("internal strobe not low at start");
	a_dout_off_csn: assert property (@(posedge ref_clk)
		disable iff (!rstn) csn |-> !serialDataOutEn)
		else $error("dout driven with chip select high");
	a_strobe_off_csn: assert property (@(posedge ref_clk)
		disable iff (!rstn) csn && ext |-> !conversionStrobeOutEn)
		else $error("external strobe driven with csn high");
	a_pd_quiet: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		powerDown |-> !serialDataOutEn && !conversionStrobeOutEn)
		else $error("outputs driven in power-down");
	a_pd_follows: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		(three_level_shutdown_in == THREE_LEVEL_SHUTDOWN_IN_LOW) [*4] |=> powerDown)
		else $error("no power-down on low shutdown");
	a_run_not_pd: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		(three_level_shutdown_in != THREE_LEVEL_SHUTDOWN_IN_LOW) [*4] |=> !powerDown)
		else $error("power-down at operating level");
	a_single_nodes: assert property (@(posedge ref_clk)
		disable iff (!rstn) samplerHold && input_topology_flag |->
		negativeNodeSel == NODE_COMMON && !positiveNodeSel[3])
		else $error("single-ended nodes wrong");
	a_diff_pairs: assert property (@(posedge ref_clk)
		disable iff (!rstn) samplerHold && !input_topology_flag |->
		positiveNodeSel[3:1] == negativeNodeSel[3:1] &&
		positiveNodeSel[0] != negativeNodeSel[0] && !positiveNodeSel[3])
		else $error("differential pair wrong");

	c_full_frame: cover property (@(posedge sclk) cnt == CNT_LSB);
	c_int_done: cover property (@(posedge ref_clk)
		$rose(conversion_strobe_out) && !ext);
	c_pdown: cover property (@(posedge ref_clk) powerDown);
endmodule

bind serial_adc_conversion_control adc_ctrl_asserts chk_u (.*);

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
	output logic sclk,
	output logic csn,
	output logic din,
	input wire logic doutWire,
	input wire logic strobe
);
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		din = 1'b0;
	end

	// Idle low, equal halves
	task automatic pulse(input int half);
		#(half);
		sclk = 1'b1;
		#(half);
		sclk = 1'b0;
	endtask

	task automatic xfer(input logic [7:0] ctrl, input int lead,
		input bit intl, output logic [11:0] res, output int waited);
		int n;
		res = 12'h000;
		waited = 0;
		csn = 1'b0;
		#200;
		for (n = 0; n < lead + 8; n++) begin
			din = (n < lead) ? 1'b0 : ctrl[7 - (n - lead)];
			pulse((n - lead >= 5) ? 350 : 16);
		end
		din = 1'b0;
		if (intl) begin
			// Let the hold edge settle before looking at the strobe
			#1;
			while (strobe !== 1'b1 && waited < 5000) begin
				#20;
				waited++;
			end
			repeat (2) pulse(16);
		end
		pulse(16);
		repeat (12) begin
			#16;
			res = {res[10:0], doutWire};
			sclk = 1'b1;
			#16;
			sclk = 1'b0;
		end
		#100;
		csn = 1'b1;
		// Start bits clocked while deselected must be ignored
		din = 1'b1;
		repeat (2) pulse(16);
		#200;
	endtask
endmodule

/* File: dv/serial_adc_conversion_control_tb_top.sv */
`timescale 1ns/1ps
module serial_adc_conversion_control_tb_top;
	import adc_ctrl_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic sclk, csn, serialDataIn;
	logic [1:0] three_level_shutdown_in = THREE_LEVEL_SHUTDOWN_IN_MID;
	logic [CHANNELS*RES_BITS-1:0] analog_input_channels = {12'hA5C,
		12'h111, 12'h222, 12'h333, 12'h444, 12'h0F0, 12'h500, 12'h300};
	logic [11:0] common_reference_input = 12'h020;
	logic serialDataOut, serialDataOutEn, conversion_strobe_out;
	logic conversionStrobeOutEn, powerDown, samplerTracking, samplerHold;
	logic polarity_select_flag, input_topology_flag;
	logic powerdown_select_high, powerdown_select_low;
	logic [3:0] positiveNodeSel, negativeNodeSel;
	logic [11:0] resultWord, res;
	wire doutWire;
	int err_total = 0;
	int check_count = 0;
	int waited;

	assign doutWire = serialDataOutEn ? serialDataOut : 1'bz;
	always #10 ref_clk = ~ref_clk;

	serial_adc_conversion_control dut_u (.*);
	host_model host_u (.sclk(sclk), .csn(csn), .din(serialDataIn),
		.doutWire(doutWire), .strobe(conversion_strobe_out));

	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic cmp(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [11:0] codeOf(input logic [11:0] p,
		input logic [11:0] n, input logic uni);
		int d;
		d = int'(p) - int'(n);
		if (uni)
			d = (d < 0) ? 0 : d;
		else
			d = (d < -2048) ? -2048 : ((d > 2047) ? 2047 : d);
		return 12'(d);
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ext_single;
		host_u.xfer(8'hFF, 0, 1'b0, res, waited);
		cmp("dout", codeOf(12'hA5C, 12'h020, 1'b1), res);
		cmp("result", codeOf(12'hA5C, 12'h020, 1'b1), resultWord);
		cmp("pos", 12'h007, {8'h00, positiveNodeSel});
		cmp("neg", {8'h00, NODE_COMMON}, {8'h00, negativeNodeSel});
		cmp("flags", 12'h00F, {8'h00, polarity_select_flag,
			input_topology_flag, powerdown_select_high,
			powerdown_select_low});
		cmp("track", 12'h001, {10'h000, samplerHold, samplerTracking});
	endtask

	task automatic t_diff;
		int k;
		for (k = 0; k < 2; k++) begin
			host_u.xfer({1'b1, k[0], 6'h03}, 3, 1'b0, res, waited);
			cmp("dout", k[0] ? codeOf(12'h500, 12'h300, 1'b0) :
				codeOf(12'h300, 12'h500, 1'b0), res);
			cmp("pos", {11'h000, k[0]}, {8'h00, positiveNodeSel});
			cmp("neg", {11'h000, ~k[0]}, {8'h00, negativeNodeSel});
			cmp("flags", 12'h003, {8'h00, polarity_select_flag,
				input_topology_flag, powerdown_select_high,
				powerdown_select_low});
		end
	endtask

	task automatic t_internal(input logic [1:0] lvl, input int lo,
		input int hi);
		@(posedge ref_clk);
		three_level_shutdown_in <= lvl;
		repeat (5) @(posedge ref_clk);
		host_u.xfer(8'h9E, 0, 1'b1, res, waited);
		cmp("dout", codeOf(12'h0F0, 12'h020, 1'b1), res);
		cmp("rate", 12'h001, {11'h000, waited >= lo && waited <= hi});
	endtask

	task automatic t_shutdown;
		@(posedge ref_clk);
		three_level_shutdown_in <= THREE_LEVEL_SHUTDOWN_IN_LOW;
		repeat (5) @(posedge ref_clk);
		cmp("pdown", 12'h001, {11'h000, powerDown});
		cmp("stben", 12'h000, {11'h000, conversionStrobeOutEn});
		three_level_shutdown_in <= THREE_LEVEL_SHUTDOWN_IN_MID;
		repeat (5) @(posedge ref_clk);
		cmp("pdown", 12'h000, {11'h000, powerDown});
		cmp("stben", 12'h001, {11'h000, conversionStrobeOutEn});
	endtask

	initial begin
		#500000;
		err_total++;
		stop_test;
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		t_ext_single;
		t_diff;
		t_internal(THREE_LEVEL_SHUTDOWN_IN_MID, 11 * FAST_DIV_CYC, 12 * FAST_DIV_CYC + 5);
		t_internal(THREE_LEVEL_SHUTDOWN_IN_HIGH, 11 * SLOW_DIV_CYC, 12 * SLOW_DIV_CYC + 5);
		t_shutdown;
		stop_test;
	end
endmodule
